// ---- lcas_baud_gen.sv ----
// half-bit tick generator driven by the selected base clock
`timescale 1ns/10ps
`default_nettype none
module lcas_baud_gen
	import lcas_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             baseTick,
	input  wire logic             restart,
	input  wire logic [DIV_W-1:0] halfDiv,
	output logic                  halfTick
);
	logic [DIV_W-1:0] cnt;
	logic [15:0]      sinceTick;
	logic             seenTick;

	initial begin
		if (DIV_W < 8) begin
			$error("baud divisor must be at least 8 bits");
		end
	end

	// restart lets the receiver realign on every start bit
	always_ff @(posedge sys_clk) begin
		if (rst || restart) begin
			// restart cycle is the first clock of the bit, else it runs long
			cnt      <= (!rst && baseTick) ? DIV_W'(1) : '0;
			halfTick <= 1'b0;
		end else begin
			halfTick <= 1'b0;
			if (baseTick) begin
				if (cnt >= halfDiv - DIV_W'(1)) begin
					cnt      <= '0;
					halfTick <= 1'b1;
				end else begin
					cnt <= cnt + DIV_W'(1);
				end
			end
		end
	end

	// helper for the rate check only
	always_ff @(posedge sys_clk) begin
		if (rst || restart) begin
			sinceTick <= '0;
			seenTick  <= 1'b0;
		end else if (halfTick) begin
			sinceTick <= 16'h0001;
			seenTick  <= 1'b1;
		end else if (sinceTick != 16'hffff) begin
			sinceTick <= sinceTick + 16'h0001;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_rate_ceiling: assert property (
		halfTick && seenTick |-> sinceTick >= 16'(MIN_HALF_CYCLES))
		else $error("half bit shorter than the rate ceiling allows");
endmodule
`default_nettype wire

// ---- lcas_buffer.sv ----
// two-entry valid/ready buffer for the transmit data path
`timescale 1ns/10ps
`default_nettype none
module lcas_buffer #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0]   count;
	logic          push;
	logic          pop;

	initial begin
		if (DEPTH < 2 || W < 1) begin
			$error("buffer needs at least two entries");
		end
	end

	assign inReady  = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = mem[rdPtr];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= nextPtr(wrPtr);
			end
			if (pop) begin
				rdPtr <= nextPtr(rdPtr);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_no_overfill: assert property (count <= (AW+1)'(DEPTH))
		else $error("buffer holds more than its depth");
	a_push_counts: assert property (push && !pop |=> count == $past(count) + 1)
		else $error("push did not raise the fill count");
endmodule
`default_nettype wire

// ---- lcas_pkg.sv ----
// shared constants and carrier types of the lin capable async serial unit
`default_nettype none
package lcas_pkg;

	// register byte addresses
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] BAUD_OFS   = 8'h04;
	localparam logic [7:0] TXDATA_OFS = 8'h08;
	localparam logic [7:0] RXDATA_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;

	// control register fields
	localparam int POS_POWER  = 0;
	localparam int POS_TXEN   = 1;
	localparam int POS_RXEN   = 2;
	localparam int POS_MSB    = 3;
	localparam int POS_LEN7   = 4;
	localparam int POS_INVERT = 5;
	localparam int POS_SBF    = 6;
	localparam int POS_BRKLEN = 8;

	// baud register fields
	localparam int POS_DIV = 0;
	localparam int POS_CKS = 8;

	// status register fields
	localparam int POS_TXBUSY  = 0;
	localparam int POS_TXFULL  = 1;
	localparam int POS_RXVALID = 2;
	localparam int POS_BRKRX   = 3;
	localparam int POS_OVERRUN = 4;
	localparam int POS_FRAMING = 5;
	localparam int POS_SBFPEND = 6;

	// reset values
	localparam logic [8:0] CTRL_RST = 9'h000;
	localparam logic [7:0] DIV_RST  = 8'hff;
	localparam logic [2:0] CKS_RST  = 3'h0;

	// timing
	localparam int CLK_PERIOD_NS   = 5;
	localparam int SYS_CLK_KHZ     = 1000000 / CLK_PERIOD_NS;
	localparam int MAX_RATE_KBPS   = 625;
	localparam int MIN_HALF_CYCLES =
		(SYS_CLK_KHZ + 2 * MAX_RATE_KBPS - 1) / (2 * MAX_RATE_KBPS);
	localparam logic [1:0] GAP_BASE_CLKS = 2'h2;
	localparam logic [4:0] SBF_MIN_BITS  = 5'h0d;
	localparam logic [4:0] SBF_MAX_BITS  = 5'h14;
	localparam logic [4:0] BRK_DET_BITS  = 5'h0b;

	typedef struct packed {
		logic [2:0] brkLen;
		logic       invert;
		logic       len7;
		logic       msbFirst;
		logic       rxEn;
		logic       txEn;
		logic       power;
	} lcas_ctrl_t;

	typedef struct packed {
		logic [2:0] cks;
		logic [7:0] div;
	} lcas_baud_t;

	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_GAP, TX_BRK}
		lcas_tx_state_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BRK}
		lcas_rx_state_t;

endpackage
`default_nettype wire

// ---- lcas_remote_node.sv ----
// remote serial node model facing the unit's line pins
`timescale 1ns/10ps
`default_nettype none
module lcas_remote_node #(
	parameter int BIT_CLKS = 320
) (
	input  wire logic sys_clk,
	input  wire logic lineIn,
	output logic      lineOut
);
	initial lineOut = 1'b1;
	task automatic hold(input logic v, input int n);
		lineOut <= v;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic send(input logic [7:0] d, input int nb, input logic msb);
		hold(1'b0, BIT_CLKS);
		for (int i = 0; i < nb; i++) begin
			hold(msb ? d[nb-1-i] : d[i], BIT_CLKS);
		end
		hold(1'b1, BIT_CLKS);
	endtask
	// idle counts edges until the start bit; sampled mid-bit
	task automatic recv(input int nb, input logic msb, input logic inv,
		output logic [7:0] d, output logic stp, output int idle);
		d = 8'h00;
		idle = 0;
		while ((lineIn ^ inv) === 1'b1 && idle < 20000) begin
			@(posedge sys_clk);
			#1;
			idle++;
		end
		repeat (BIT_CLKS / 2) @(posedge sys_clk);
		for (int i = 0; i < nb; i++) begin
			repeat (BIT_CLKS) @(posedge sys_clk);
			#1;
			if (msb) begin
				d[nb-1-i] = lineIn ^ inv;
			end else begin
				d[i] = lineIn ^ inv;
			end
		end
		repeat (BIT_CLKS) @(posedge sys_clk);
		#1;
		stp = lineIn ^ inv;
	endtask
	task automatic low_len(input logic inv, output int n);
		int w;
		w = 0;
		n = 0;
		while ((lineIn ^ inv) === 1'b1 && w < 20000) begin
			@(posedge sys_clk);
			#1;
			w++;
		end
		while ((lineIn ^ inv) === 1'b0 && n < 20000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask
endmodule
`default_nettype wire

// ---- lcas_serial.sv ----
// lin capable async serial unit with apb registers
`timescale 1ns/10ps
`default_nettype none
module lcas_serial
	import lcas_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_rx_in,
	output logic             serial_tx_out
);
	lcas_ctrl_t     ctrl;
	lcas_baud_t     baud;
	lcas_tx_state_t txState;
	lcas_rx_state_t rxState;
	logic [7:0]  presc;
	logic        baseTick;
	logic        txEnB;
	logic        rxEnB;
	logic        txActive;
	logic        rxActive;
	logic [7:0]  halfDiv;
	logic        txHalf;
	logic        rxHalf;
	logic        txPhase;
	logic        rxPhase;
	logic        txLine;
	logic [7:0]  txData;
	logic [4:0]  txIdx;
	logic [1:0]  gapCnt;
	logic        sbfPend;
	logic        sbfTake;
	logic        bufInReady;
	logic        bufOutValid;
	logic        bufPop;
	logic [7:0]  bufOut;
	logic        rxSync1;
	logic        rxSync2;
	logic [7:0]  rxShift;
	logic [4:0]  rxIdx;
	logic [4:0]  rxLowCnt;
	logic        rxDone;
	logic [7:0]  rxData;
	logic        rxValid;
	logic        brkRx;
	logic        overrun;
	logic        framing;
	logic        access;
	logic        done;
	logic        wrDone;
	logic        rxSample;
	logic        txBitEnd;

	function automatic logic mapped(input logic [7:0] a);
		if (a == CTRL_OFS) mapped = 1'b1;
		else if (a == BAUD_OFS) mapped = 1'b1;
		else if (a == TXDATA_OFS) mapped = 1'b1;
		else if (a == RXDATA_OFS) mapped = 1'b1;
		else if (a == STATUS_OFS) mapped = 1'b1;
		else mapped = 1'b0;
	endfunction

	// position of the n-th line bit inside the data byte
	function automatic logic [2:0] bitPos(input logic [4:0] n,
			input logic len7, input logic msb);
		logic [2:0] last;
		last = len7 ? 3'h6 : 3'h7;
		bitPos = msb ? last - n[2:0] : n[2:0];
	endfunction

	// programmed half-bit divisor, raised to the smallest one that keeps the rate ceiling
	function automatic logic [7:0] clampDiv(input lcas_baud_t b);
		logic [9:0] lim;
		lim = 10'((MIN_HALF_CYCLES + (1 << b.cks) - 1) >> b.cks);
		clampDiv = ({2'h0, b.div} < lim) ? lim[7:0] : b.div;
	endfunction

	// apb: pready rises one cycle into the access phase
	assign access = psel & penable & ~pready;
	assign done   = psel & penable & pready;
	assign wrDone = done & pwrite;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			// a full transmit buffer stalls the write until a slot frees
			pready  <= access & ~(pwrite && paddr == TXDATA_OFS
				&& !bufInReady);
			pslverr <= access & ~mapped(paddr);
			prdata  <= 32'h0000_0000;
			if (access && !pwrite) begin
				if (paddr == CTRL_OFS) begin
					prdata[POS_BRKLEN+:3] <= ctrl.brkLen;
					prdata[POS_INVERT]    <= ctrl.invert;
					prdata[POS_LEN7]      <= ctrl.len7;
					prdata[POS_MSB]       <= ctrl.msbFirst;
					prdata[POS_RXEN]      <= ctrl.rxEn;
					prdata[POS_TXEN]      <= ctrl.txEn;
					prdata[POS_POWER]     <= ctrl.power;
				end else if (paddr == BAUD_OFS) begin
					prdata[POS_DIV+:8] <= baud.div;
					prdata[POS_CKS+:3] <= baud.cks;
				end else if (paddr == RXDATA_OFS) begin
					prdata[7:0] <= rxData;
				end else if (paddr == STATUS_OFS) begin
					prdata[POS_TXBUSY]  <= (txState != TX_IDLE) | bufOutValid;
					prdata[POS_TXFULL]  <= ~bufInReady;
					prdata[POS_RXVALID] <= rxValid;
					prdata[POS_BRKRX]   <= brkRx;
					prdata[POS_OVERRUN] <= overrun;
					prdata[POS_FRAMING] <= framing;
					prdata[POS_SBFPEND] <= sbfPend;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= lcas_ctrl_t'(CTRL_RST);
			baud <= {CKS_RST, DIV_RST};
		end else if (wrDone && paddr == CTRL_OFS) begin
			ctrl.brkLen   <= pwdata[POS_BRKLEN+:3];
			ctrl.invert   <= pwdata[POS_INVERT];
			ctrl.len7     <= pwdata[POS_LEN7];
			ctrl.msbFirst <= pwdata[POS_MSB];
			ctrl.rxEn     <= pwdata[POS_RXEN];
			ctrl.txEn     <= pwdata[POS_TXEN];
			ctrl.power    <= pwdata[POS_POWER];
		end else if (wrDone && paddr == BAUD_OFS) begin
			baud.div <= pwdata[POS_DIV+:8];
			baud.cks <= pwdata[POS_CKS+:3];
		end
	end

	// base clock: sys_clk divided by two to the power cks
	always_ff @(posedge sys_clk) begin
		if (rst || !ctrl.power) begin
			presc <= 8'h00;
		end else begin
			presc <= presc + 8'h01;
		end
	end
	assign baseTick = ctrl.power
		&& ((presc & 8'((1 << baud.cks) - 1)) == 8'((1 << baud.cks) - 1));

	// enables take effect on a base clock, so a fast re-set can be missed
	always_ff @(posedge sys_clk) begin
		if (rst || !ctrl.power) begin
			txEnB <= 1'b0;
			rxEnB <= 1'b0;
		end else if (baseTick) begin
			txEnB <= ctrl.txEn;
			rxEnB <= ctrl.rxEn;
		end
	end
	assign txActive = ctrl.power & txEnB;
	assign rxActive = ctrl.power & rxEnB;
	assign halfDiv  = clampDiv(baud);

	lcas_baud_gen #(.DIV_W(8)) txBaud (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.baseTick (baseTick),
		.restart  (txState == TX_IDLE),
		.halfDiv  (halfDiv),
		.halfTick (txHalf)
	);

	lcas_baud_gen #(.DIV_W(8)) rxBaud (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.baseTick (baseTick),
		.restart  (rxState == RX_IDLE),
		.halfDiv  (halfDiv),
		.halfTick (rxHalf)
	);

	lcas_buffer #(.W(8), .DEPTH(2)) txBuf (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.inValid  (wrDone && paddr == TXDATA_OFS),
		.inReady  (bufInReady),
		.inData   (pwdata[7:0]),
		.outValid (bufOutValid),
		.outReady (bufPop),
		.outData  (bufOut)
	);

	// break request: a new request wins over the take
	assign sbfTake = txActive && txState == TX_IDLE && sbfPend;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sbfPend <= 1'b0;
		end else begin
			sbfPend <= (sbfPend & ~sbfTake)
				| (wrDone && paddr == CTRL_OFS && pwdata[POS_SBF]);
		end
	end

	assign bufPop   = txActive && txState == TX_IDLE && !sbfPend
		&& bufOutValid;
	assign txBitEnd = txHalf & txPhase;

	// transmitter, independent of the receiver
	always_ff @(posedge sys_clk) begin
		if (rst || !txActive) begin
			txState <= TX_IDLE;
			txLine  <= 1'b1;
			txPhase <= 1'b0;
			txIdx   <= 5'h00;
			txData  <= 8'h00;
			gapCnt  <= 2'h0;
		end else begin
			if (txHalf) begin
				txPhase <= ~txPhase;
			end
			case (txState)
			TX_IDLE: begin
				txPhase <= 1'b0;
				txIdx   <= 5'h00;
				if (sbfPend) begin
					txState <= TX_BRK;
					txLine  <= 1'b0;
				end else if (bufOutValid) begin
					txData  <= bufOut;
					txState <= TX_START;
					txLine  <= 1'b0;
				end
			end
			TX_START: begin
				if (txBitEnd) begin
					txState <= TX_DATA;
					txLine  <= txData[bitPos(5'h00, ctrl.len7, ctrl.msbFirst)];
				end
			end
			TX_DATA: begin
				if (txBitEnd) begin
					if (txIdx == (ctrl.len7 ? 5'h06 : 5'h07)) begin
						txState <= TX_STOP;
						txLine  <= 1'b1;
					end else begin
						txIdx  <= txIdx + 5'h01;
						txLine <= txData[bitPos(txIdx + 5'h01, ctrl.len7,
							ctrl.msbFirst)];
					end
				end
			end
			TX_STOP: begin
				if (txBitEnd) begin
					txState <= TX_GAP;
					// idle cycle ahead of the next start is the last gap clock
					gapCnt  <= GAP_BASE_CLKS - 2'h1;
				end
			end
			TX_GAP: begin
				if (baseTick) begin
					gapCnt <= gapCnt - 2'h1;
					if (gapCnt == 2'h1) begin
						txState <= TX_IDLE;
					end
				end
			end
			TX_BRK: begin
				if (txBitEnd) begin
					if (txIdx == SBF_MIN_BITS - 5'h01 + {2'h0, ctrl.brkLen}
							|| txIdx == SBF_MAX_BITS - 5'h01) begin
						txState <= TX_STOP;
						txLine  <= 1'b1;
					end else begin
						txIdx <= txIdx + 5'h01;
					end
				end
			end
			default: txState <= TX_IDLE;
			endcase
		end
	end

	// pin holds its last value if sys_clk stops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serial_tx_out <= 1'b1;
		end else begin
			serial_tx_out <= txLine ^ ctrl.invert;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rxSync1 <= 1'b1;
			rxSync2 <= 1'b1;
		end else begin
			rxSync1 <= serial_rx_in;
			rxSync2 <= rxSync1;
		end
	end

	assign rxSample = rxHalf & rxPhase;

	// receiver; inversion never applies here
	always_ff @(posedge sys_clk) begin
		if (rst || !rxActive) begin
			rxState  <= RX_IDLE;
			rxPhase  <= 1'b0;
			rxIdx    <= 5'h00;
			rxShift  <= 8'h00;
			rxLowCnt <= 5'h00;
			rxDone   <= 1'b0;
		end else begin
			rxDone <= 1'b0;
			if (rxHalf) begin
				rxPhase <= ~rxPhase;
			end
			case (rxState)
			RX_IDLE: begin
				rxPhase <= 1'b0;
				if (!rxSync2) begin
					rxState <= RX_START;
				end
			end
			RX_START: begin
				if (rxHalf) begin
					rxPhase <= 1'b0;
					rxIdx   <= 5'h00;
					rxShift <= 8'h00;
					rxState <= rxSync2 ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rxSample) begin
					rxShift[bitPos(rxIdx, ctrl.len7, ctrl.msbFirst)]
						<= rxSync2;
					if (rxIdx == (ctrl.len7 ? 5'h06 : 5'h07)) begin
						rxState <= RX_STOP;
					end else begin
						rxIdx <= rxIdx + 5'h01;
					end
				end
			end
			RX_STOP: begin
				if (rxSample) begin
					if (rxSync2) begin
						rxDone  <= 1'b1;
						rxState <= RX_IDLE;
					end else begin
						rxState  <= RX_BRK;
						rxLowCnt <= ctrl.len7 ? 5'h09 : 5'h0a;
					end
				end
			end
			RX_BRK: begin
				if (rxSample && rxSync2) begin
					rxState <= RX_IDLE;
				end else if (rxSample && rxLowCnt != 5'h1f) begin
					rxLowCnt <= rxLowCnt + 5'h01;
				end
			end
			default: rxState <= RX_IDLE;
			endcase
		end
	end

	// sticky flags: a new event wins over a same-cycle clear or read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rxData  <= 8'h00;
			rxValid <= 1'b0;
			overrun <= 1'b0;
			brkRx   <= 1'b0;
			framing <= 1'b0;
		end else begin
			if (rxDone) begin
				rxData <= rxShift;
			end
			rxValid <= rxDone
				| (rxValid & ~(done && !pwrite && paddr == RXDATA_OFS));
			overrun <= (rxDone & rxValid
				& ~(done && !pwrite && paddr == RXDATA_OFS))
				| (overrun & ~(wrDone && paddr == STATUS_OFS
				&& pwdata[POS_OVERRUN]));
			brkRx <= (rxState == RX_BRK && rxSample && rxSync2
				&& rxLowCnt > BRK_DET_BITS)
				| (brkRx & ~(wrDone && paddr == STATUS_OFS
				&& pwdata[POS_BRKRX]));
			framing <= (rxState == RX_BRK && rxSample && rxSync2
				&& rxLowCnt <= BRK_DET_BITS)
				| (framing & ~(wrDone && paddr == STATUS_OFS
				&& pwdata[POS_FRAMING]));
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_start_bit_low: assert property (txState == TX_START |-> !txLine)
		else $error("start bit not low");
	a_stop_bit_high: assert property (txState == TX_STOP |-> txLine)
		else $error("stop bit not high");
	a_gap_length: assert property (
		$rose(txState == TX_GAP) |-> txLine ##1 txLine)
		else $error("inter frame gap shorter than two clocks");
	a_break_bounded: assert property (
		txState == TX_BRK |-> txIdx < SBF_MAX_BITS && !txLine)
		else $error("break field too long or not low");
	a_break_flag: assert property (
		$rose(brkRx) |-> $past(rxLowCnt) > BRK_DET_BITS)
		else $error("break flagged for a short low");
	a_power_off: assert property (
		!ctrl.power |=> txState == TX_IDLE && rxState == RX_IDLE)
		else $error("paths active while power is off");
	a_enable_sync: assert property (
		$rose(txEnB) |-> $past(baseTick) && $past(ctrl.txEn))
		else $error("transmit enable not taken on a base clock");
	a_rx_restart: assert property (
		rxState == RX_IDLE && !rxSync2 && rxActive |=> rxState == RX_START)
		else $error("receiver missed a start bit");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
endmodule
`default_nettype wire

// ---- test_lcas_serial.sv ----
// self-checking bench of the lin capable async serial unit
`timescale 1ns/10ps
`default_nettype none
module test_lcas_serial
	import lcas_pkg::*;
;
	localparam int          BITC = 320;
	localparam logic [31:0] ON   = 32'h7;
	logic        sys_clk  = 1'b0;
	logic        rst      = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        serialRx;
	logic        serialTx;
	int          errors   = 0;
	int          compares = 0;
	always #2.5 sys_clk = ~sys_clk;
	lcas_serial u_lcas_serial (
		.sys_clk       (sys_clk),
		.rst           (rst),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.serial_rx_in  (serialRx),
		.serial_tx_out (serialTx)
	);
	lcas_remote_node #(.BIT_CLKS(BITC)) u_lcas_remote_node (
		.sys_clk (sys_clk),
		.lineIn  (serialTx),
		.lineOut (serialRx)
	);
	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] x);
		compares++;
		if (s !== x) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20000);
		if (n >= 20000) errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(nm, r & m, x);
	endtask
	task automatic txf(input string nm, input logic [7:0] d, input int nb,
		input logic msb, input logic inv);
		logic [7:0] g;
		logic       s;
		int         idle;
		fork
			wr(TXDATA_OFS, {24'h0, d});
			u_lcas_remote_node.recv(nb, msb, inv, g, s, idle);
		join
		check(nm, {24'h0, g}, {24'h0, d});
		check("stop bit", {31'h0, s}, 32'h1);
		repeat (BITC) @(posedge sys_clk);
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		check("idle line", {31'h0, serialTx}, 32'h1);
		rdc("ctrl", CTRL_OFS, '1, 32'h0);
		rdc("baud", BAUD_OFS, '1, {21'h0, CKS_RST, DIV_RST});
		rdc("status", STATUS_OFS, '1, 32'h0);
		apb(1'b1, 8'h14, 32'hff, r, e);
		check("unmapped wr err", {31'h0, e}, 32'h1);
		apb(1'b0, 8'h14, 32'h0, r, e);
		check("unmapped rd", {r[30:0], e}, 32'h1);
		wr(BAUD_OFS, 32'h0a0);
		wr(CTRL_OFS, 32'h1);
		wr(CTRL_OFS, ON);
		rdc("ctrl on", CTRL_OFS, '1, ON);
		$display("test reset done");
	endtask
	task automatic t_tx();
		txf("lsb8 byte", 8'ha5, 8, 1'b0, 1'b0);
		wr(CTRL_OFS, ON | 32'h38);
		// halved base clock with halved divisor keeps the same bit time
		wr(BAUD_OFS, 32'h150);
		rdc("baud cks", BAUD_OFS, '1, 32'h150);
		check("inverted idle", {31'h0, serialTx}, 32'h0);
		txf("msb7 inverted", 8'h35, 7, 1'b1, 1'b1);
		wr(BAUD_OFS, 32'h0a0);
		wr(CTRL_OFS, ON);
		$display("test tx done");
	endtask
	task automatic t_duplex();
		fork
			txf("duplex tx", 8'h3c, 8, 1'b0, 1'b0);
			u_lcas_remote_node.send(8'h5a, 8, 1'b0);
		join
		rdc("rx valid", STATUS_OFS, '1, 32'h4);
		rdc("rx byte", RXDATA_OFS, '1, 32'h5a);
		rdc("rx cleared", STATUS_OFS, '1, 32'h0);
		$display("test duplex done");
	endtask
	task automatic t_b2b();
		logic [7:0] g;
		logic       s;
		int         idle;
		// four writes: the last stalls until the buffer frees a slot
		fork
			for (int k = 0; k < 4; k++) wr(TXDATA_OFS, 32'h10 + k);
			for (int i = 0; i < 4; i++) begin
				u_lcas_remote_node.recv(8, 1'b0, 1'b0, g, s, idle);
				check("b2b byte", {24'h0, g}, 32'h10 + i);
				if (i > 0) check("b2b gap", idle, BITC / 2 + 2);
			end
		join
		repeat (BITC) @(posedge sys_clk);
		$display("test back to back done");
	endtask
	task automatic t_brk_tx();
		int n;
		for (int b = 0; b < 8; b += 7) begin
			fork
				wr(CTRL_OFS, ON | 32'h40 | (32'(b) << POS_BRKLEN));
				u_lcas_remote_node.low_len(1'b0, n);
			join
			check("break length", n, (13 + b) * BITC);
			repeat (2 * BITC) @(posedge sys_clk);
		end
		$display("test break tx done");
	endtask
	task automatic t_brk_rx();
		u_lcas_remote_node.hold(1'b0, 12 * BITC);
		u_lcas_remote_node.hold(1'b1, 2 * BITC);
		rdc("twelve low", STATUS_OFS, 32'h28, 32'h8);
		wr(STATUS_OFS, 32'h38);
		rdc("flags cleared", STATUS_OFS, 32'h38, 32'h0);
		u_lcas_remote_node.hold(1'b0, 11 * BITC);
		u_lcas_remote_node.hold(1'b1, 2 * BITC);
		rdc("eleven low", STATUS_OFS, 32'h28, 32'h20);
		wr(STATUS_OFS, 32'h38);
		rdc("no byte after breaks", STATUS_OFS, 32'h3c, 32'h0);
		$display("test break rx done");
	endtask
	task automatic t_power_off();
		int n;
		n = 0;
		wr(CTRL_OFS, 32'h0);
		fork
			wr(TXDATA_OFS, 32'h66);
			u_lcas_remote_node.send(8'h99, 8, 1'b0);
			repeat (12 * BITC) begin
				@(posedge sys_clk);
				if (serialTx !== 1'b1) n++;
			end
		join
		check("line quiet", n, 0);
		rdc("no rx", STATUS_OFS, 32'h4, 32'h0);
		$display("test power off done");
	endtask
	task automatic final_report();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_tx();
		t_duplex();
		t_b2b();
		t_brk_tx();
		t_brk_rx();
		t_power_off();
		final_report();
	end
	// run needs about 50k cycles; a hang still ends below 100k
	initial begin
		repeat (80000) @(posedge sys_clk);
		errors++;
		final_report();
	end
endmodule
`default_nettype wire
